// file: logic/mic_defs.vh
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH
// register addresses (data memory, 8-bit)
`define MIC_ADDR_CTRL      8'h0b
`define MIC_ADDR_CTRL_MIR  8'h8b
`define MIC_ADDR_PFLAG1    8'h0c
`define MIC_ADDR_PFLAG2    8'h0d
`define MIC_ADDR_PEN1      8'h8c
`define MIC_ADDR_PEN2      8'h8d
`define MIC_ADDR_ISTAT     8'h90
`define MIC_ADDR_ICLR      8'h91
`define MIC_ADDR_IEN       8'h92
// control register fields
`define MIC_GLB_EN_BIT     7
`define MIC_PGE_BIT        6
`define MIC_TOE_BIT        5
`define MIC_PINE_BIT       4
`define MIC_PCE_BIT        3
`define MIC_TOF_BIT        2
`define MIC_PINF_BIT       1
`define MIC_PCF_BIT        0
// peripheral flag / enable bit of the converter
`define MIC_CONV_BIT       6
// reset values
`define MIC_CTRL_RST       8'h00
`define MIC_PREG_RST       8'h00
// interrupt vector address
`define MIC_VECTOR         13'h0004
// latency counts in instruction cycles
`define MIC_LAT_MIN        3'h3
`define MIC_LAT_MAX        3'h4
`endif

// file: logic/mic_interrupt_control.v
// How it works
// R1: four sources: pin edge, timer overflow, upper port change, converter done.
// R2: flags set on events regardless of individual or global enables.
// R3: global enable bit 7 permits enabled sources; zero blocks all requests. irq_out is not gated by it.
// R4: global enable plus flag and enable together request a vector.
// R5: any reset clears the global enable.
// R6: return-from-interrupt instruction sets the global enable again.
// R7: on acceptance clear global enable, push return address, load pc 0004h.
// R8: external event to vector takes three or four instruction cycles.
// R9: software polls flags and clears them before re-enabling.
// R10: control register at 0bh, mirrored at 8bh.
// R11: bit7 global, 6 periph, 5..3 timer/pin/port enables, 2..0 timer/pin/port flags.
// R12: peripheral flags and enables sit in separate registers; group enable in control.
// R13: port-change flag set when any upper port pin changes; software clears.
// R14: acceptance during a clear of global enable still vectors; return sets it again.
// R15: software repeats clearing the global enable until readback shows zero.
// R16: request is or of flag and enable, gated by global enable, held until cleared.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.vh"

////////////////////////////////////////////////////////////////
// change detector for a group of synchronous pins; the previous sample
// resets to a constant, so the first cycle after reset is masked to keep
// a pin that idles high from faking an edge
module mic_edge_detect #(
	parameter W = 1
) (
	input  wire         core_clk,
	input  wire         rst_b,
	input  wire [W-1:0] pin_in,
	output wire [W-1:0] rise_evt,
	output wire [W-1:0] fall_evt,
	output wire         change_evt
);

	reg [W-1:0] prev_reg;
	reg         armed_reg;

	// edges only once a real previous sample exists
	assign rise_evt   = {W{armed_reg}} & pin_in & ~prev_reg;
	assign fall_evt   = {W{armed_reg}} & ~pin_in & prev_reg;
	assign change_evt = armed_reg & |(pin_in ^ prev_reg);

	// previous sample; inputs taken as synchronous already
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_reg  <= {W{1'b0}};
			armed_reg <= 1'b0;
		end else begin
			prev_reg  <= pin_in;
			armed_reg <= 1'b1;
		end
	end

endmodule // mic_edge_detect

module mic_interrupt_control #(
	parameter PC_W = 13
) (
	input  wire            core_clk,
	input  wire            rst_b,
	input  wire            instr_cycle_en,
	input  wire [7:0]      reg_addr,
	input  wire [7:0]      reg_wdata,
	input  wire            reg_wr,
	input  wire            reg_rd,
	output reg  [7:0]      reg_rdata,
	input  wire            ext_irq_pin,
	input  wire            ext_edge_rising,
	input  wire            timer_overflow,
	input  wire [3:0]      upper_port_pins,
	input  wire            converter_done,
	input  wire            return_from_irq_instr,
	input  wire [PC_W-1:0] current_pc,
	output reg             irq_request,
	output reg             vector_take,
	output reg  [PC_W-1:0] vector_pc,
	output reg  [PC_W-1:0] push_addr,
	output reg             push_en,
	output reg             irq_out
);

	////////////////////////////////////////////////////////////////
	// input edge detection
	wire       pin_rise;
	wire       pin_fall;
	wire       pin_event;
	wire       port_event;
	wire       conv_event;

	// one detector per source group except the timer, whose overflow pulse is used directly; unused edge kinds left open
	mic_edge_detect #(
		.W (1)
	) pin_det_u (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pin_in     (ext_irq_pin),
		.rise_evt   (pin_rise),
		.fall_evt   (pin_fall),
		.change_evt ()
	);
	mic_edge_detect #(
		.W (4)
	) port_det_u (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pin_in     (upper_port_pins),
		.rise_evt   (),
		.fall_evt   (),
		.change_evt (port_event) // R13
	);
	mic_edge_detect #(
		.W (1)
	) conv_det_u (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pin_in     (converter_done),
		.rise_evt   (conv_event),
		.fall_evt   (),
		.change_evt ()
	);

	// pin edge selected by polarity input
	assign pin_event = ext_edge_rising ? pin_rise : pin_fall;

	////////////////////////////////////////////////////////////////
	// register state
	reg  [7:0] ctrl_reg;
	reg  [7:0] ctrl_next;
	reg  [7:0] pflag1_reg;
	reg  [7:0] pflag1_next;
	reg  [7:0] pflag2_reg;
	reg  [7:0] pen1_reg;
	reg  [7:0] pen2_reg;
	reg  [7:0] istat_reg;
	reg  [7:0] istat_next;
	reg  [7:0] ien_reg;
	wire       wr_ctrl;
	wire       wr_pflag1;
	wire       wr_pflag2;
	wire       wr_pen1;
	wire       wr_pen2;
	wire       wr_ien;
	wire       wr_iclr;
	wire       accept;
	wire [7:0] evt_vec;
	wire       periph_pend;
	wire       pend_any;

	assign wr_ctrl   = reg_wr & ((reg_addr == `MIC_ADDR_CTRL) |
	                             (reg_addr == `MIC_ADDR_CTRL_MIR)); // R10
	assign wr_pflag1 = reg_wr & (reg_addr == `MIC_ADDR_PFLAG1);

	// one strobe per writable register, none for the status register; the clear register has no storage behind it
	assign wr_pflag2 = reg_wr & (reg_addr == `MIC_ADDR_PFLAG2);
	assign wr_pen1   = reg_wr & (reg_addr == `MIC_ADDR_PEN1);
	assign wr_pen2   = reg_wr & (reg_addr == `MIC_ADDR_PEN2);
	assign wr_ien    = reg_wr & (reg_addr == `MIC_ADDR_IEN);
	assign wr_iclr   = reg_wr & (reg_addr == `MIC_ADDR_ICLR);

	// peripheral pending from separate flag/enable registers
	assign periph_pend = |(pflag1_reg & pen1_reg) | |(pflag2_reg & pen2_reg); // R12

	// flag-and-enable or, global gate applied at request
	assign pend_any = (ctrl_reg[`MIC_TOF_BIT]  & ctrl_reg[`MIC_TOE_BIT])  |
	                  (ctrl_reg[`MIC_PINF_BIT] & ctrl_reg[`MIC_PINE_BIT]) |
	                  (ctrl_reg[`MIC_PCF_BIT]  & ctrl_reg[`MIC_PCE_BIT])  |
	                  (periph_pend & ctrl_reg[`MIC_PGE_BIT]); // R1 R16

	// acceptance happens when the latency counter expires
	reg  [2:0] lat_cnt_reg;
	reg        in_flight_reg;
	// last count value before acceptance, three boundaries after launch
	localparam [2:0] LAT_LAST = `MIC_LAT_MIN - 3'h1;
	assign accept = in_flight_reg & instr_cycle_en &
	                (lat_cnt_reg == LAT_LAST); // R8

	// event vector for the sticky status block
	assign evt_vec = {4'h0, conv_event, port_event, timer_overflow, pin_event};

	// control register next value: events set, software writes, core edits global enable
	always @* begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
			ctrl_next = reg_wdata;
		if (return_from_irq_instr)
			ctrl_next[`MIC_GLB_EN_BIT] = 1'b1; // R6 R14
		if (accept)
			ctrl_next[`MIC_GLB_EN_BIT] = 1'b0; // R7
		// set wins over a simultaneous software clear
		if (timer_overflow)
			ctrl_next[`MIC_TOF_BIT] = 1'b1; // R2
		if (pin_event)
			ctrl_next[`MIC_PINF_BIT] = 1'b1; // R2
		if (port_event)
			ctrl_next[`MIC_PCF_BIT] = 1'b1; // R2 R13
	end

	// converter flag in peripheral flag register, set beats clear
	always @* begin
		pflag1_next = wr_pflag1 ? reg_wdata : pflag1_reg;
		if (conv_event)
			pflag1_next[`MIC_CONV_BIT] = 1'b1; // R2
	end

	// sticky status: write-one-to-clear, event wins
	always @* begin
		istat_next = istat_reg;
		if (wr_iclr)
			istat_next = istat_reg & ~reg_wdata;
		istat_next = istat_next | evt_vec;
	end

	// register storage
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg   <= `MIC_CTRL_RST; // R5
			pflag1_reg <= `MIC_PREG_RST;
			pflag2_reg <= `MIC_PREG_RST;
			pen1_reg   <= `MIC_PREG_RST;
			pen2_reg   <= `MIC_PREG_RST;
			istat_reg  <= `MIC_PREG_RST;
			ien_reg    <= `MIC_PREG_RST;
		end else begin
			ctrl_reg   <= ctrl_next; // R11
			pflag1_reg <= pflag1_next;
			istat_reg  <= istat_next;
			if (wr_pflag2)
				pflag2_reg <= reg_wdata;
			if (wr_pen1)
				pen1_reg <= reg_wdata;
			if (wr_pen2)
				pen2_reg <= reg_wdata;
			if (wr_ien)
				ien_reg <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// vectoring sequence
	// request sampled on an instruction cycle boundary; the counter spans the
	// remaining cycles so the core sees three or four cycles from the event
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lat_cnt_reg   <= 3'h0;
			in_flight_reg <= 1'b0;
		end else if (instr_cycle_en) begin
			if (accept) begin
				in_flight_reg <= 1'b0;
				lat_cnt_reg   <= 3'h0;
			end else if (in_flight_reg) begin
				lat_cnt_reg <= lat_cnt_reg + 3'h1; // R8
			end else if (ctrl_reg[`MIC_GLB_EN_BIT] & pend_any) begin
				// once launched, a global enable clear does not cancel it
				in_flight_reg <= 1'b1; // R4 R14
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// registered outputs
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_request <= 1'b0;
			vector_take <= 1'b0;
			vector_pc   <= {PC_W{1'b0}};
			push_addr   <= {PC_W{1'b0}};
			push_en     <= 1'b0;
			irq_out     <= 1'b0;
		end else begin
			irq_request <= ctrl_reg[`MIC_GLB_EN_BIT] & pend_any; // R3 R16
			vector_take <= accept;
			push_en     <= accept; // R7
			if (accept) begin
				vector_pc <= `MIC_VECTOR; // R7
				push_addr <= current_pc;
			end
			irq_out <= |(istat_next & ien_reg);
		end
	end

	////////////////////////////////////////////////////////////////
	// read port, one cycle latency; unmapped reads zero, clear reg reads zero
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`MIC_ADDR_CTRL:     reg_rdata <= ctrl_reg; // R10
				`MIC_ADDR_CTRL_MIR: reg_rdata <= ctrl_reg; // R10
				`MIC_ADDR_PFLAG1:   reg_rdata <= pflag1_reg;
				`MIC_ADDR_PFLAG2:   reg_rdata <= pflag2_reg;
				`MIC_ADDR_PEN1:     reg_rdata <= pen1_reg;
				`MIC_ADDR_PEN2:     reg_rdata <= pen2_reg;
				`MIC_ADDR_ISTAT:    reg_rdata <= istat_reg;
				`MIC_ADDR_IEN:      reg_rdata <= ien_reg;
				default:            reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule // mic_interrupt_control
`default_nettype wire

// file: verification/mic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// core sequencer stand-in: one instruction boundary every four clocks
module mic_core_model (
	input  wire logic core_clk,
	input  wire logic rst_b,
	output var  logic instr_cycle_en
);
	logic [1:0] phase_reg;
	// free-running divider, restarts on reset so latency counts stay aligned
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			phase_reg <= 2'h0;
		else
			phase_reg <= phase_reg + 2'h1;
	end
	assign instr_cycle_en = (phase_reg == 2'h3);
endmodule // mic_core_model
`default_nettype wire

// file: verification/mic_interrupt_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module mic_interrupt_control_test;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        pin = 1'b0;
	logic        tov = 1'b0;
	logic        conv = 1'b0;
	logic        ret = 1'b0;
	logic        rise = 1'b1;
	logic [3:0]  port = 4'h0;
	wire         ice, irq_request, vector_take, push_en, irq_out;
	wire  [7:0]  reg_rdata;
	wire  [12:0] vector_pc, push_addr;
	int          n_errors = 0, n_checks = 0, cyc = 0, i;
	mic_core_model core_u (.core_clk(core_clk), .rst_b(rst_b), .instr_cycle_en(ice));
	mic_interrupt_control dut_u (.core_clk(core_clk), .rst_b(rst_b), .instr_cycle_en(ice),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_irq_pin(pin), .ext_edge_rising(rise),
		.timer_overflow(tov), .upper_port_pins(port), .converter_done(conv),
		.return_from_irq_instr(ret), .current_pc(13'h0123), .irq_request(irq_request),
		.vector_take(vector_take), .vector_pc(vector_pc), .push_addr(push_addr),
		.push_en(push_en), .irq_out(irq_out));
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// strobes last one cycle; data sampled once the edge has landed
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, e);
	endtask
	task automatic wait_vec;
		for (i = 0; i < 40 && vector_take !== 1'b1; i++)
			@(negedge core_clk);
		cmp(vector_take, 1'b1);
	endtask
	// handler exit: clear flags first, then return
	task automatic leave;
		wr(8'h0b, 8'h38);
		@(posedge core_clk) ret <= 1'b1;
		@(posedge core_clk) ret <= 1'b0;
		rd(8'h0b, 8'hb8);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial forever #25 core_clk = ~core_clk;
	// hang guard, far above the roughly 150 cycles the run needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			conclude;
		end
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(8'h0b, 8'h00);
		wr(8'h0b, 8'h38);
		rd(8'h8b, 8'h38);
		@(posedge core_clk) tov <= 1'b1;
		@(posedge core_clk) tov <= 1'b0;
		rd(8'h0b, 8'h3c);
		@(posedge core_clk) port <= 4'h8;
		rd(8'h0b, 8'h3d);
		@(posedge core_clk) pin <= 1'b1;
		rd(8'h0b, 8'h3f);
		cmp(irq_request, 1'b0);
		@(posedge core_clk) conv <= 1'b1;
		rd(8'h0c, 8'h40);
		rd(8'h90, 8'h0f);
		wr(8'h92, 8'h0f);
		repeat (2) @(posedge core_clk);
		#1 cmp(irq_out, 1'b1);
		wr(8'h92, 8'h00);
		repeat (2) @(posedge core_clk);
		#1 cmp(irq_out, 1'b0);
		wr(8'h92, 8'h0f);
		wr(8'h91, 8'h0f);
		rd(8'h91, 8'h00);
		rd(8'h90, 8'h00);
		cmp(irq_out, 1'b0);
		rd(8'h55, 8'h00);
		wr(8'h0b, 8'hbf);
		wait_vec;
		cmp(vector_pc, 13'h0004);
		cmp(push_addr, 13'h0123);
		rd(8'h0b, 8'h3f);
		leave;
		@(posedge core_clk) tov <= 1'b1;
		@(posedge core_clk) tov <= 1'b0;
		for (i = 0; i < 8 && irq_request !== 1'b1; i++)
			@(negedge core_clk);
		cmp(irq_request, 1'b1);
		@(negedge ice);
		wr(8'h0b, 8'h3c);
		wait_vec;
		leave;
		wr(8'h0b, 8'h38);
		rd(8'h0b, 8'h38);
		@(posedge core_clk) {pin, port} <= 5'h00;
		@(posedge core_clk) rst_b <= 1'b0;
		@(posedge core_clk) rst_b <= 1'b1;
		rd(8'h0b, 8'h00);
		rd(8'h0c, 8'h00);
		@(posedge core_clk) {rise, pin, conv} <= 3'b010;
		@(posedge core_clk) {pin, conv} <= 2'b01;
		rd(8'h0b, 8'h02);
		wr(8'h8c, 8'h40);
		wr(8'h0b, 8'hc0);
		wait_vec;
		cmp(push_en, 1'b1);
		conclude;
	end
endmodule // mic_interrupt_control_test
`default_nettype wire

// file: verification/mic_irq_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.vh"
module mic_irq_properties #(
	parameter PC_W = 13
) (
	input wire logic            core_clk,
	input wire logic            rst_b,
	input wire logic            instr_cycle_en,
	input wire logic            reg_rd,
	input wire logic [7:0]      reg_rdata,
	input wire logic [PC_W-1:0] current_pc,
	input wire logic            irq_request,
	input wire logic            vector_take,
	input wire logic [PC_W-1:0] vector_pc,
	input wire logic [PC_W-1:0] push_addr,
	input wire logic            push_en
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// vectoring outputs travel together
	chk_vec_target: assert property (vector_take |-> vector_pc == `MIC_VECTOR)
		else $error("vector target wrong");
	chk_push_pair: assert property (push_en == vector_take)
		else $error("push and vector apart");
	chk_push_addr: assert property (vector_take |-> push_addr == $past(current_pc))
		else $error("pushed address wrong");
	chk_vec_pulse: assert property (vector_take |=> !vector_take)
		else $error("vector pulse too long");
	chk_vec_boundary: assert property (vector_take |-> $past(instr_cycle_en))
		else $error("vector off instruction boundary");
	// read data only in the cycle after a strobe
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	// global enable cleared on entry, so the request must fall
	chk_req_drop: assert property (vector_take |-> ##2 !irq_request)
		else $error("request held after entry");
	chk_req_vectors: assert property (irq_request && $past(irq_request) && instr_cycle_en
		|-> ##[1:20] vector_take)
		else $error("request not vectored in time");
endmodule // mic_irq_properties
bind mic_interrupt_control mic_irq_properties #(.PC_W(PC_W)) chk_u (.core_clk, .rst_b,
	.instr_cycle_en, .reg_rd, .reg_rdata, .current_pc, .irq_request, .vector_take,
	.vector_pc, .push_addr, .push_en);
`default_nettype wire
